// ===== design/lfg_defs.svh
`ifndef LFG_DEFS_SVH
`define LFG_DEFS_SVH

// Register byte addresses
`define LFG_ADDR_FAULT_HI    8'h06
`define LFG_ADDR_FAULT_LO    8'h07
`define LFG_ADDR_GROUP       8'h09
`define LFG_ADDR_THR_FIRST   8'h0a
`define LFG_ADDR_THR_LAST    8'h0d
`define LFG_ADDR_GPO_SEL     8'h0f

// Fault restart mode word, bit n-1 is fault n, 1 = auto restart
`define LFG_FAULT_RST        12'habe
`define LFG_FAULT_WMASK      12'he96
`define LFG_FAULT_FIXED      12'h028
`define LFG_FAULT_HI_MSB     11
`define LFG_FAULT_HI_LSB     8
`define LFG_FAULT_LO_MSB     7
`define LFG_FAULT_LO_LSB     0
`define LFG_FAULT_HI_FLD     3:0

// Grouping field
`define LFG_GROUP_MSB        6
`define LFG_GROUP_RST        7'h00

// Short threshold codes, two per byte
`define LFG_THR_ODD          2:0
`define LFG_THR_EVEN         6:4
`define LFG_THR_RST          3'h0
`define LFG_THR_BASE_DV      8'h78
`define LFG_THR_STEP_DV      8'h0a

// Output selection fields
`define LFG_AUX_OUTPUT_ONE_SELECT_FLD         4:3
`define LFG_AUX_OUTPUT_TWO_SELECT_FLD         1:0
`define LFG_GPO_SEL_RST      2'h0

// Timing of the PWM period mark
`define LFG_CLK_MHZ          32'h19
`define LFG_PWM_MARK_NS      32'h12c
`define LFG_PWM_MARK_CYC     ((`LFG_PWM_MARK_NS * `LFG_CLK_MHZ + 32'h3e7) / 32'h3e8)

`endif

// ===== design/lfg_pkg.sv
package lfg_pkg;
  typedef logic [7:0] lfg_byte_t;
  typedef logic [15:0] lfg_on_time_t;
  typedef logic [2:0] lfg_chan_t;

  typedef enum logic [1:0] {
    LFG_O1_SOFT_START = 2'b00,
    LFG_O1_CLK_DIV4   = 2'b01,
    LFG_O1_PWM_MARK   = 2'b10,
    LFG_O1_THERMAL    = 2'b11
  } lfg_out1_sel_e;

  typedef enum logic [1:0] {
    LFG_O2_TEST_FAIL  = 2'b00,
    LFG_O2_SW_ILIM    = 2'b01,
    LFG_O2_BOOST_SW   = 2'b10,
    LFG_O2_RESERVED   = 2'b11
  } lfg_out2_sel_e;
endpackage

// ===== design/lfg_slot_map.sv
`timescale 1ns/1ns
// Resolves polyphase grouping chains into a leading channel per channel
module lfg_slot_map (
  input  wire logic [6:0]                    group_bits,  // Set bit joins channel to lower one
  input  wire lfg_pkg::lfg_on_time_t [7:0]   on_time_in,  // Own on-time per channel
  output lfg_pkg::lfg_chan_t [7:0]           leader,      // Slot index each channel starts in
  output lfg_pkg::lfg_on_time_t [7:0]        on_time_out, // On-time each channel runs with
  output logic [7:0]                         slot_used    // Slot is used by its own channel
);
  import lfg_pkg::*;

  // Channel 1 has no lower neighbour and always leads its own slot
  assign leader[0]      = 3'h0;
  assign on_time_out[0] = on_time_in[0];
  assign slot_used[0]   = 1'b1;

  // Each grouped channel follows the leader of the next lower channel
  genvar gi;
  generate
    for (gi = 1; gi < 8; gi++) begin : g_chain
      assign leader[gi]      = group_bits[gi-1] ? leader[gi-1] : 3'(gi);
      assign on_time_out[gi] = on_time_in[leader[gi]];
      assign slot_used[gi]   = ~group_bits[gi-1];
    end
  endgenerate
endmodule // lfg_slot_map

// ===== design/lfg_top.sv
`timescale 1ns/1ns
`include "lfg_defs.svh"
module lfg_top (
  input  wire logic                          clk,              // System clock 25 MHz
  input  wire logic                          rst_b,            // Async reset, active low
  input  wire logic                          reg_wr_en,        // Register write strobe
  input  wire logic                          reg_rd_en,        // Register read strobe
  input  wire lfg_pkg::lfg_byte_t            reg_addr,         // Register byte address
  input  wire lfg_pkg::lfg_byte_t            reg_wdata,        // Write data
  output lfg_pkg::lfg_byte_t                 reg_rdata_ff,     // Read data
  output logic                               reg_rvalid_ff,    // Read data valid pulse
  output logic [11:0]                        fault_auto_ff,    // Per fault: 1 auto restart
  input  wire lfg_pkg::lfg_on_time_t [7:0]   channel_on_time,  // Own on-time per channel
  output lfg_pkg::lfg_chan_t [7:0]           chan_slot_ff,     // Start slot per channel
  output lfg_pkg::lfg_on_time_t [7:0]        chan_on_time_ff,  // Effective on-time
  output logic [7:0]                         slot_used_ff,     // Slot owned by own channel
  input  wire lfg_pkg::lfg_byte_t [7:0]      string_volt_dv,   // String voltage, 0.1 V units
  output logic [7:0]                         string_short_ff,  // Short detected per channel
  input  wire logic                          soft_start_busy,  // Boost soft start running
  input  wire logic                          pwm_period_start, // Pulse at PWM period start
  input  wire logic                          thermal_derating, // Thermal derating active
  input  wire logic                          startup_test_bad, // Startup test failed
  input  wire logic                          sw_current_limit, // Switch current limit hit
  input  wire logic                          boost_switching,  // Boost is switching
  output logic                               aux_out_one_ff,   // First general output pin
  output logic                               aux_out_two_ff    // Second general output pin
);
  import lfg_pkg::*;

  logic [11:0]                fault_mode_ff;
  logic [11:0]                nxt_fault_mode;
  logic [6:0]                 group_ff;
  lfg_chan_t [7:0]            thr_code_ff;
  lfg_out1_sel_e              out1_sel_ff;
  lfg_out2_sel_e              out2_sel_ff;
  lfg_byte_t                  nxt_rdata;
  lfg_chan_t [7:0]            leader;
  lfg_on_time_t [7:0]         grp_on_time;
  logic [7:0]                 grp_slot_used;
  lfg_byte_t [7:0]            thr_dv;
  logic [1:0]                 div_cnt_ff;
  logic [3:0]                 mark_cnt_ff;
  logic                       thr_sel;
  logic [1:0]                 thr_idx;
  logic                       nxt_out_one;
  logic                       nxt_out_two;

  localparam logic [3:0] MARK_CYC = 4'(`LFG_PWM_MARK_CYC);

  // Threshold register window decode
  assign thr_sel = (reg_addr >= `LFG_ADDR_THR_FIRST) && (reg_addr <= `LFG_ADDR_THR_LAST);
  assign thr_idx = 2'(reg_addr - `LFG_ADDR_THR_FIRST);

  // Fault word: only programmable bits move, fixed bits are forced
  always_comb begin
    nxt_fault_mode = fault_mode_ff;
    if (reg_wr_en && (reg_addr == `LFG_ADDR_FAULT_HI)) begin
      nxt_fault_mode[`LFG_FAULT_HI_MSB:`LFG_FAULT_HI_LSB] = reg_wdata[`LFG_FAULT_HI_FLD];
    end
    if (reg_wr_en && (reg_addr == `LFG_ADDR_FAULT_LO)) begin
      nxt_fault_mode[`LFG_FAULT_LO_MSB:`LFG_FAULT_LO_LSB] = reg_wdata;
    end
    nxt_fault_mode = (nxt_fault_mode & `LFG_FAULT_WMASK) | `LFG_FAULT_FIXED;
  end

  // Fault restart mode register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_mode_ff <= `LFG_FAULT_RST;
    end else begin
      fault_mode_ff <= nxt_fault_mode;
    end
  end

  // Fault mode seen by the protection logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_auto_ff <= `LFG_FAULT_RST;
    end else begin
      fault_auto_ff <= fault_mode_ff;
    end
  end

  // Grouping register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      group_ff <= `LFG_GROUP_RST;
    end else if (reg_wr_en && (reg_addr == `LFG_ADDR_GROUP)) begin
      group_ff <= reg_wdata[`LFG_GROUP_MSB:0];
    end
  end

  // Threshold registers, one per channel pair
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_thr
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          thr_code_ff[2*gp]   <= `LFG_THR_RST;
          thr_code_ff[2*gp+1] <= `LFG_THR_RST;
        end else if (reg_wr_en && thr_sel && (thr_idx == 2'(gp))) begin
          thr_code_ff[2*gp]   <= reg_wdata[`LFG_THR_ODD];
          thr_code_ff[2*gp+1] <= reg_wdata[`LFG_THR_EVEN];
        end
      end
    end
  endgenerate

  // Output selection register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out1_sel_ff <= lfg_out1_sel_e'(`LFG_GPO_SEL_RST);
      out2_sel_ff <= lfg_out2_sel_e'(`LFG_GPO_SEL_RST);
    end else if (reg_wr_en && (reg_addr == `LFG_ADDR_GPO_SEL)) begin
      out1_sel_ff <= lfg_out1_sel_e'(reg_wdata[`LFG_AUX_OUTPUT_ONE_SELECT_FLD]);
      out2_sel_ff <= lfg_out2_sel_e'(reg_wdata[`LFG_AUX_OUTPUT_TWO_SELECT_FLD]);
    end
  end

  // Read data mux; unused bits and unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr == `LFG_ADDR_FAULT_HI) begin
      nxt_rdata = {4'h0, fault_mode_ff[`LFG_FAULT_HI_MSB:`LFG_FAULT_HI_LSB]};
    end else if (reg_addr == `LFG_ADDR_FAULT_LO) begin
      nxt_rdata = fault_mode_ff[`LFG_FAULT_LO_MSB:`LFG_FAULT_LO_LSB];
    end else if (reg_addr == `LFG_ADDR_GROUP) begin
      nxt_rdata = {1'b0, group_ff};
    end else if (thr_sel) begin
      nxt_rdata = {1'b0, thr_code_ff[{thr_idx, 1'b1}], 1'b0, thr_code_ff[{thr_idx, 1'b0}]};
    end else if (reg_addr == `LFG_ADDR_GPO_SEL) begin
      nxt_rdata = {3'h0, out1_sel_ff, 1'b0, out2_sel_ff};
    end
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff  <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata_ff <= nxt_rdata;
      end
    end
  end

  // Grouping chain resolution
  lfg_slot_map u_slot_map (
    .group_bits  (group_ff),
    .on_time_in  (channel_on_time),
    .leader      (leader),
    .on_time_out (grp_on_time),
    .slot_used   (grp_slot_used)
  );

  // Registered slot plan for the PWM sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_slot_ff    <= '0;
      chan_on_time_ff <= '0;
      slot_used_ff    <= 8'h00;
    end else begin
      chan_slot_ff    <= leader;
      chan_on_time_ff <= grp_on_time;
      slot_used_ff    <= grp_slot_used;
    end
  end

  // Threshold decode and short compare per channel
  genvar gc;
  generate
    for (gc = 0; gc < 8; gc++) begin : g_short
      assign thr_dv[gc] = 8'(`LFG_THR_BASE_DV - ({5'h00, thr_code_ff[gc]} * `LFG_THR_STEP_DV));
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          string_short_ff[gc] <= 1'b0;
        end else begin
          string_short_ff[gc] <= string_volt_dv[gc] > thr_dv[gc];
        end
      end
    end
  endgenerate

  // Divide-by-four of the system clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_ff <= 2'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 2'h1;
    end
  end

  // Stretches each PWM period start into a short low mark
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mark_cnt_ff <= 4'h0;
    end else if (pwm_period_start) begin
      mark_cnt_ff <= MARK_CYC;
    end else if (mark_cnt_ff != 4'h0) begin
      mark_cnt_ff <= mark_cnt_ff - 4'h1;
    end
  end

  // First output source mux
  always_comb begin
    case (out1_sel_ff)
      LFG_O1_SOFT_START: nxt_out_one = soft_start_busy;
      LFG_O1_CLK_DIV4:   nxt_out_one = div_cnt_ff[1];
      LFG_O1_PWM_MARK:   nxt_out_one = (mark_cnt_ff == 4'h0);
      LFG_O1_THERMAL:    nxt_out_one = ~thermal_derating;
      default:           nxt_out_one = 1'b0;
    endcase
  end

  // Second output source mux; reserved code drives low
  always_comb begin
    case (out2_sel_ff)
      LFG_O2_TEST_FAIL: nxt_out_two = startup_test_bad;
      LFG_O2_SW_ILIM:   nxt_out_two = ~sw_current_limit;
      LFG_O2_BOOST_SW:  nxt_out_two = boost_switching;
      default:          nxt_out_two = 1'b0;
    endcase
  end

  // Output pin flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_out_one_ff <= 1'b0;
      aux_out_two_ff <= 1'b0;
    end else begin
      aux_out_one_ff <= nxt_out_one;
      aux_out_two_ff <= nxt_out_two;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_mark_start;
    pwm_period_start && (out1_sel_ff == LFG_O1_PWM_MARK);
  endsequence

  sequence s_mark_low;
    (!aux_out_one_ff)[*8];
  endsequence

  chk_fixed_fault_bits: assert property (
    (fault_mode_ff[8] == 1'b0) && (fault_mode_ff[6] == 1'b0) && (fault_mode_ff[0] == 1'b0)
    && (fault_mode_ff[5] == 1'b1) && (fault_mode_ff[3] == 1'b1))
    else $error("fixed fault mode bit changed");

  chk_fault_hi_write: assert property (
    reg_wr_en && (reg_addr == `LFG_ADDR_FAULT_HI)
    |=> ##1 (fault_auto_ff[11:9] == $past(reg_wdata[3:1], 2)))
    else $error("fault high write not applied");

  chk_fault_lo_write: assert property (
    reg_wr_en && (reg_addr == `LFG_ADDR_FAULT_LO) |=> ##1 (fault_auto_ff[7] == $past(reg_wdata[7], 2))
    && (fault_auto_ff[4] == $past(reg_wdata[4], 2))
    && (fault_auto_ff[2:1] == $past(reg_wdata[2:1], 2)))
    else $error("fault low write not applied");

  chk_fault_word_read: assert property (
    reg_rd_en && (reg_addr == 8'h06) |=> reg_rvalid_ff && (reg_rdata_ff[7:4] == 4'h0))
    else $error("fault high byte upper bits not zero");

  chk_group_chan_two: assert property (
    group_ff[0] && $stable(group_ff) |=> (chan_slot_ff[1] == 3'h0) && !slot_used_ff[1])
    else $error("grouped channel 2 not in slot of channel 1");

  chk_group_chain: assert property (
    (group_ff[6:5] == 2'b11) && !group_ff[4] && $stable(group_ff)
    |=> (chan_slot_ff[7] == 3'h5) && (chan_on_time_ff[7] == $past(channel_on_time[5])))
    else $error("chain not led by lowest member");

  chk_short_thr_max: assert property (
    (thr_code_ff[1] == 3'h7) && (string_volt_dv[1] == 8'h33) |=> string_short_ff[1])
    else $error("5 V threshold not applied");

  chk_pwm_mark: assert property (
    s_mark_start ##1 (out1_sel_ff == LFG_O1_PWM_MARK) |=> s_mark_low)
    else $error("PWM period mark too short");

  chk_clk_div_four: assert property (
    (out1_sel_ff == LFG_O1_CLK_DIV4)[*4] |-> aux_out_one_ff != $past(aux_out_one_ff, 2))
    else $error("output one not clock divided by four");

  chk_thermal_out: assert property (
    (out1_sel_ff == LFG_O1_THERMAL) && thermal_derating |=> !aux_out_one_ff)
    else $error("thermal derating not shown low");

  chk_out_two_resv: assert property (
    (out2_sel_ff == LFG_O2_RESERVED) |=> !aux_out_two_ff)
    else $error("reserved output two not low");

  chk_soft_start_out: assert property (
    (out1_sel_ff == LFG_O1_SOFT_START) |=> (aux_out_one_ff == $past(soft_start_busy)))
    else $error("output one does not follow soft start");

  chk_thermal_normal: assert property (
    (out1_sel_ff == LFG_O1_THERMAL) && !thermal_derating |=> aux_out_one_ff)
    else $error("thermal normal not shown high");

  chk_out_two_test: assert property (
    (out2_sel_ff == LFG_O2_TEST_FAIL) |=> (aux_out_two_ff == $past(startup_test_bad)))
    else $error("output two does not follow startup test");

  chk_out_two_ilim: assert property (
    (out2_sel_ff == LFG_O2_SW_ILIM) |=> (aux_out_two_ff == !$past(sw_current_limit)))
    else $error("output two does not show current limit low");

  chk_out_two_boost: assert property (
    (out2_sel_ff == LFG_O2_BOOST_SW) |=> (aux_out_two_ff == $past(boost_switching)))
    else $error("output two does not follow boost switching");

  chk_short_thr_min: assert property (
    (thr_code_ff[0] == `LFG_THR_RST) && (string_volt_dv[0] == `LFG_THR_BASE_DV)
    |=> !string_short_ff[0])
    else $error("short flagged at 12 V threshold");

  chk_ungrouped_own: assert property (
    !group_ff[2] |=> slot_used_ff[3] && (chan_slot_ff[3] == 3'h3)
    && (chan_on_time_ff[3] == $past(channel_on_time[3])))
    else $error("ungrouped channel 4 not in own slot");

  chk_read_answer: assert property (
    reg_rd_en |=> reg_rvalid_ff)
    else $error("read strobe not answered");

  chk_group_read: assert property (
    reg_rd_en && (reg_addr == `LFG_ADDR_GROUP)
    |=> (reg_rdata_ff[7] == 1'b0) && (reg_rdata_ff[6:0] == $past(group_ff)))
    else $error("grouping read back wrong");
endmodule // lfg_top

// ===== verification/lfg_host.sv
`timescale 1ns/1ns
// Host model for the byte register port, one strobe per access
module lfg_host (
  input  wire logic          clk,       // System clock
  output logic               reg_wr_en, // Write strobe
  output logic               reg_rd_en, // Read strobe
  output lfg_pkg::lfg_byte_t reg_addr,  // Byte address
  output lfg_pkg::lfg_byte_t reg_wdata  // Write data
);
  import lfg_pkg::*;
  // Idle bus
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Strobe on a falling edge, held over one rising edge, then released
  task automatic acc(input logic wr, input lfg_byte_t a, input lfg_byte_t d);
    @(negedge clk);
    reg_wr_en = wr;
    reg_rd_en = ~wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule // lfg_host

// ===== verification/led_fault_group_gpo_config_bench.sv
`timescale 1ns/1ns
`include "lfg_defs.svh"
module led_fault_group_gpo_config_bench;
  import lfg_pkg::*;
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               wr_en;
  logic               rd_en;
  lfg_byte_t          addr;
  lfg_byte_t          wdata;
  lfg_byte_t          rdata;
  logic               rvalid;
  logic [11:0]        fault;
  lfg_on_time_t [7:0] on_in = '0;
  lfg_on_time_t [7:0] on_out;
  lfg_chan_t [7:0]    slot;
  logic [7:0]         used;
  logic [7:0]         short;
  lfg_byte_t [7:0]    volt = '0;
  logic               ss = 1'b0;
  logic               pwm = 1'b0;
  logic               thd = 1'b0;
  logic               tbad = 1'b0;
  logic               ilim = 1'b0;
  logic               bsw = 1'b0;
  logic               o1;
  logic               o2;
  int                 err_count = 0;
  int                 num_checks = 0;
  int                 cyc = 0;
  lfg_byte_t          exp_q[$];

  lfg_host lfg_host_inst (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata));
  lfg_top lfg_top_inst (.clk(clk), .rst_b(rst_b), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid),
    .fault_auto_ff(fault), .channel_on_time(on_in), .chan_slot_ff(slot),
    .chan_on_time_ff(on_out), .slot_used_ff(used), .string_volt_dv(volt),
    .string_short_ff(short), .soft_start_busy(ss), .pwm_period_start(pwm),
    .thermal_derating(thd), .startup_test_bad(tbad), .sw_current_limit(ilim),
    .boost_switching(bsw), .aux_out_one_ff(o1), .aux_out_two_ff(o2));

  // 25 MHz clock
  always #20 clk = ~clk;

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic summarize;
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Read request leaves its expected byte for the watcher
  task automatic rd(input lfg_byte_t a, input lfg_byte_t e);
    exp_q.push_back(e);
    lfg_host_inst.acc(1'b0, a, 8'h00);
  endtask

  // Watcher pairs each read answer with the oldest note
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      chk("rdata", (exp_q.size() > 0) ? {8'h00, exp_q.pop_front()} : 16'hxxxx, {8'h00, rdata});
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    logic [11:0] r;
    logic [11:0] e;
    logic [6:0] g;
    logic [7:0] c;
    logic [7:0] es;
    logic [2:0] code[8];
    int ld;
    int t;
    int n;
    void'($urandom(32'h36287365));
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk("fault", 12'habe, fault);
    chk("used", 8'hff, used);
    rd(8'h06, 8'h0a);
    rd(8'h07, 8'hbe);
    rd(8'h09, 8'h00);
    rd(8'h0d, 8'h00);
    rd(8'h0f, 8'h00);
    rd(8'h08, 8'h00);
    // Fault modes: all zeros, all ones, then random words
    for (int i = 0; i < 6; i++) begin
      r = (i < 2) ? {12{i[0]}} : 12'($urandom);
      lfg_host_inst.acc(1'b1, 8'h06, {4'hf, r[11:8]});
      lfg_host_inst.acc(1'b1, 8'h07, r[7:0]);
      e = (r & `LFG_FAULT_WMASK) | `LFG_FAULT_FIXED;
      repeat (2) @(negedge clk);
      chk("fault", {4'h0, e}, {4'h0, fault});
      rd(8'h06, {4'h0, e[11:8]});
      rd(8'h07, e[7:0]);
    end
    // Grouping chains with fresh on-times
    for (int i = 0; i < 5; i++) begin
      g = (i == 0) ? 7'h7f : (i == 1) ? 7'h60 : 7'($urandom);
      for (int k = 0; k < 8; k++) on_in[k] = 16'($urandom);
      lfg_host_inst.acc(1'b1, 8'h09, {1'b0, g});
      rd(8'h09, {1'b0, g});
      repeat (3) @(negedge clk);
      for (int k = 0; k < 8; k++) begin
        ld = k;
        while (ld > 0 && g[ld-1]) ld--;
        chk("slot", 16'(ld), {13'h0, slot[k]});
        chk("ontime", on_in[ld], on_out[k]);
        chk("used", 16'(!(k > 0 && g[k-1])), {15'h0, used[k]});
      end
    end
    // Threshold codes, voltages just below, at and above, then random
    for (int a = 0; a < 4; a++) begin
      c = (a == 0) ? 8'h70 : 8'($urandom) & 8'h77;
      lfg_host_inst.acc(1'b1, 8'(8'h0a + a), c);
      rd(8'(8'h0a + a), c);
      code[2*a] = c[2:0];
      code[2*a+1] = c[6:4];
    end
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 8; k++) begin
        t = 120 - 10 * int'(code[k]);
        volt[k] = (p < 3) ? 8'(t + p - 1) : 8'($urandom);
        es[k] = int'(volt[k]) > t;
      end
      repeat (3) @(negedge clk);
      chk("short", {8'h00, es}, {8'h00, short});
    end
    // Every pairing of the two output selectors
    for (int s = 0; s < 16; s++) begin
      c = {3'b000, 2'(s >> 2), 1'b0, 2'(s)};
      lfg_host_inst.acc(1'b1, 8'h0f, c);
      rd(8'h0f, c);
      {ss, thd, tbad, ilim, bsw} = 5'($urandom);
      repeat (3) @(negedge clk);
      chk("out2", {15'h0, (c[1:0] == 2'b00) ? tbad : (c[1:0] == 2'b01) ? ~ilim :
        (c[1:0] == 2'b10) ? bsw : 1'b0}, {15'h0, o2});
      n = 0;
      case (c[4:3])
        2'b00: chk("out1", {15'h0, ss}, {15'h0, o1});
        2'b11: chk("out1", {15'h0, ~thd}, {15'h0, o1});
        2'b01: begin
          repeat (8) begin
            @(negedge clk);
            n += int'(o1 === 1'b1);
          end
          chk("div4", 16'h4, 16'(n));
        end
        default: begin
          chk("mark", 16'h1, {15'h0, o1});
          pwm = 1'b1;
          @(negedge clk);
          pwm = 1'b0;
          repeat (12) begin
            @(negedge clk);
            n += int'(o1 === 1'b0);
          end
          chk("mark", 16'h8, 16'(n));
        end
      endcase
    end
    repeat (3) @(negedge clk);
    chk("pending", 16'h0, 16'(exp_q.size()));
    summarize();
  end
endmodule // led_fault_group_gpo_config_bench
